/* File: inc/dio_pkg.sv */
`default_nettype none
package dio_pkg;
	// =====================================================
	// Register map (byte addresses)
	localparam logic [7:0] AUX_CTRL_ADDR = 8'h00;
	localparam logic [7:0] AUX_STATUS_ADDR = 8'h04;
	localparam logic [7:0] AUX_USER_ADDR = 8'h08;
	localparam logic [7:0] RELAY_ADDR = 8'h0C;
	localparam logic [7:0] DOUT_CTRL_ADDR = 8'h10;
	localparam logic [7:0] DOUT_THRESH0_ADDR = 8'h14;
	localparam logic [7:0] DOUT_THRESH1_ADDR = 8'h18;
	localparam logic [7:0] DOUT_STATUS_ADDR = 8'h1C;
	// =====================================================
	// Field positions
	localparam int DIR_LSB = 0;
	localparam int INV_LSB = 8;
	localparam int EMU_LSB = 16;
	localparam int EMU_W = 5;
	localparam int OUTLVL_LSB = 8;
	localparam int FSEL_W = 5;
	localparam int FSEL_STRIDE = 8;
	localparam int ULVL_LSB = 16;
	localparam int RELAY_BIT = 4;
	// =====================================================
	// Reset values and special codes
	localparam logic [EMU_W-1:0] EMU_RESET = 5'h00;
	localparam logic [EMU_W-1:0] EMU_AUX_IO = 5'h0A;
	localparam logic [7:0] PAIR_RESET = 8'h00;
	localparam logic RELAY_POLICY_RESET = 1'b0;
	localparam logic [31:0] THRESH_RESET = 32'h00000000;
	// =====================================================
	// Output function codes
	typedef enum logic [FSEL_W-1:0] {
		FN_USER = 5'h00,
		FN_MAINS_READY = 5'h01,
		FN_SW_LIMIT = 5'h02,
		FN_MOVE_DONE = 5'h03,
		FN_IN_POSITION = 5'h04,
		FN_POS_ABOVE = 5'h05,
		FN_POS_BELOW = 5'h06,
		FN_WARNING = 5'h07,
		FN_ENABLED = 5'h08,
		FN_RESERVED9 = 5'h09,
		FN_BRAKE = 5'h0A,
		FN_FAULT = 5'h0B,
		FN_SPEED_ABOVE = 5'h0C,
		FN_SPEED_BELOW = 5'h0D,
		FN_HOMED = 5'h0E,
		FN_POS_SWITCH = 5'h0F,
		FN_CMD_BUFFER = 5'h10,
		FN_INDEX = 5'h13,
		FN_NO_CTRL_STOP = 5'h14,
		FN_FAULT_POWER = 5'h15
	} out_func_t;
endpackage
`default_nettype wire

/* File: rtl/aux_pair_channel.sv */
`timescale 1ns/1ns
`default_nettype none
module aux_pair_channel (
	input wire logic pclk, // Logic clock
	input wire logic presetn, // Async reset, active low
	input wire logic pos_in, // Plus leg from pin
	input wire logic neg_in, // Minus leg from pin
	output logic pos_out, // Plus leg drive value
	output logic neg_out, // Minus leg drive value
	output logic pos_oe, // Plus leg enable
	output logic neg_oe, // Minus leg enable
	input wire logic active, // Emulation mode selects this I/O
	input wire logic dir, // 1 output, 0 input
	input wire logic inv, // Polarity invert
	input wire logic user_level, // Level to drive in output direction
	output logic in_level // Decoded input level
);
	// =====================================================
	// Synchroniser
	logic pos_meta, neg_meta, pos_sync, neg_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_meta <= 1'b0;
			neg_meta <= 1'b0;
			pos_sync <= 1'b0;
			neg_sync <= 1'b0;
		end else begin
			pos_meta <= pos_in;
			neg_meta <= neg_in;
			pos_sync <= pos_meta;
			neg_sync <= neg_meta;
		end
	end
	// =====================================================
	// Decode and drive
	wire use_inv = active & inv;
	wire plus_high = pos_sync & ~neg_sync;
	wire minus_high = neg_sync & ~pos_sync;
	wire drive_level = user_level ^ use_inv;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_level <= 1'b0;
			pos_out <= 1'b0;
			neg_out <= 1'b1;
		end else begin
			in_level <= use_inv ? minus_high : plus_high;
			pos_out <= drive_level;
			neg_out <= ~drive_level;
		end
	end
	// Driving only when the emulation mode owns the pair avoids fighting field inputs
	assign pos_oe = active & dir;
	assign neg_oe = active & dir;
endmodule // aux_pair_channel
`default_nettype wire

/* File: rtl/drive_digital_io_config.sv */
`timescale 1ns/1ns
`default_nettype none
module drive_digital_io_config import dio_pkg::*; #(
	parameter int NUM_PAIRS = 3,
	parameter int NUM_OUTS = 2
) (
	input wire logic pclk, // APB clock, 100 MHz
	input wire logic presetn, // APB reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [NUM_PAIRS-1:0] pair_pos_in, // Connector plus legs in
	input wire logic [NUM_PAIRS-1:0] pair_neg_in, // Connector minus legs in
	output logic [NUM_PAIRS-1:0] pair_pos_out, // Connector plus legs out
	output logic [NUM_PAIRS-1:0] pair_neg_out, // Connector minus legs out
	output logic [NUM_PAIRS-1:0] pair_pos_oe, // Plus leg enables
	output logic [NUM_PAIRS-1:0] pair_neg_oe, // Minus leg enables
	input wire logic drive_fault, // Any fault present
	input wire logic drive_enabled, // Drive enabled
	input wire logic mains_ready, // Mains ready
	input wire logic sw_limit, // Software limit reached
	input wire logic move_done, // Move complete
	input wire logic in_position, // In position
	input wire logic drive_warning, // Warning present
	input wire logic motor_brake, // Brake command
	input wire logic homing_done, // Homing complete
	input wire logic [7:0] position_switch_flags, // Position switch flags
	input wire logic cmd_buffer_active, // Command buffer active
	input wire logic encoder_index, // Encoder index pulse
	input wire logic ctrl_stop_active, // Controlled stop active
	input wire logic fault_power_off, // Fault disabling power stage
	input wire logic signed [31:0] position, // Actual position
	input wire logic signed [31:0] velocity, // Actual velocity
	output logic [NUM_OUTS-1:0] dout, // Digital outputs, bit 0 is first
	output logic relay_closed // Fault relay closed
);
	// =====================================================
	// Elaboration checks
	if (NUM_PAIRS < 1 || NUM_PAIRS > 8) begin : g_bad_pairs
		$error("NUM_PAIRS must be 1 to 8");
	end
	if (NUM_OUTS != 2) begin : g_bad_outs
		$error("NUM_OUTS must be 2");
	end

	// =====================================================
	// Registers
	logic [NUM_PAIRS-1:0] pair_direction;
	logic [NUM_PAIRS-1:0] pair_polarity_invert;
	logic [EMU_W-1:0] emulation_mode_select;
	logic [NUM_PAIRS-1:0] aux_user_level;
	logic fault_relay_policy;
	logic [FSEL_W-1:0] output_function_select [NUM_OUTS];
	logic [NUM_OUTS-1:0] user_output_level;
	logic [31:0] output_threshold_param [NUM_OUTS];
	logic [NUM_PAIRS-1:0] input_level_readback;

	// =====================================================
	// Bus decode
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr_en = access & pwrite;
	wire hit_ctrl = paddr == AUX_CTRL_ADDR;
	wire hit_status = paddr == AUX_STATUS_ADDR;
	wire hit_user = paddr == AUX_USER_ADDR;
	wire hit_relay = paddr == RELAY_ADDR;
	wire hit_dctrl = paddr == DOUT_CTRL_ADDR;
	wire hit_th0 = paddr == DOUT_THRESH0_ADDR;
	wire hit_th1 = paddr == DOUT_THRESH1_ADDR;
	wire hit_dstat = paddr == DOUT_STATUS_ADDR;
	wire mapped = hit_ctrl | hit_status | hit_user | hit_relay | hit_dctrl | hit_th0 | hit_th1 | hit_dstat;
	wire [NUM_OUTS-1:0] hit_th = {hit_th1, hit_th0};
	wire aux_active = emulation_mode_select == EMU_AUX_IO;

	// Zero wait states: read data is captured in the setup cycle
	assign pready = access;
	assign pslverr = access & ~mapped;

	// =====================================================
	// Output function evaluation
	function automatic logic abs_gt(input logic signed [31:0] v, input logic [31:0] t);
		logic [31:0] mag;
		mag = v[31] ? 32'(-v) : 32'(v);
		return mag > t;
	endfunction

	function automatic logic abs_lt(input logic signed [31:0] v, input logic [31:0] t);
		logic [31:0] mag;
		mag = v[31] ? 32'(-v) : 32'(v);
		return mag < t;
	endfunction

	function automatic logic func_value(
		input logic [FSEL_W-1:0] sel,
		input logic ulvl,
		input logic [31:0] thr,
		input logic [15:0] flags,
		input logic signed [31:0] pos,
		input logic signed [31:0] vel
	);
		logic r;
		r = 1'b0;
		unique case (out_func_t'(sel))
			FN_USER: r = ulvl;
			FN_MAINS_READY: r = flags[0];
			FN_SW_LIMIT: r = flags[1];
			FN_MOVE_DONE: r = flags[2];
			FN_IN_POSITION: r = flags[3];
			FN_POS_ABOVE: r = pos > $signed(thr);
			FN_POS_BELOW: r = pos < $signed(thr);
			FN_WARNING: r = flags[4];
			FN_ENABLED: r = flags[5];
			FN_BRAKE: r = flags[6];
			FN_FAULT: r = flags[7];
			FN_SPEED_ABOVE: r = abs_gt(vel, thr);
			FN_SPEED_BELOW: r = abs_lt(vel, thr);
			FN_HOMED: r = flags[8];
			FN_POS_SWITCH: r = flags[9];
			FN_CMD_BUFFER: r = flags[10];
			FN_INDEX: r = flags[11];
			FN_NO_CTRL_STOP: r = flags[12];
			FN_FAULT_POWER: r = flags[13];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Status sources arrive from logic on this clock, so no synchroniser
	wire [15:0] status_flags = {
		2'b00,
		fault_power_off,
		~ctrl_stop_active,
		encoder_index,
		cmd_buffer_active,
		|position_switch_flags,
		homing_done,
		drive_fault,
		motor_brake,
		drive_enabled,
		drive_warning,
		in_position,
		move_done,
		sw_limit,
		mains_ready
	};

	logic [NUM_OUTS-1:0] next_dout;
	logic [NUM_OUTS-1:0] fsel_write;
	logic [FSEL_W-1:0] fsel_wdata [NUM_OUTS];

	// =====================================================
	// Per-output logic
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUTS; gi++) begin : g_out
			assign fsel_wdata[gi] = pwdata[gi*FSEL_STRIDE +: FSEL_W];
			assign fsel_write[gi] = wr_en & hit_dctrl;
			assign next_dout[gi] = func_value(output_function_select[gi], user_output_level[gi],
				output_threshold_param[gi], status_flags, position, velocity);
			wire fsel_change = fsel_write[gi] & (fsel_wdata[gi] != output_function_select[gi]);

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					output_function_select[gi] <= FN_USER;
					user_output_level[gi] <= 1'b0;
					output_threshold_param[gi] <= THRESH_RESET;
				end else begin
					if (fsel_write[gi]) begin
						output_function_select[gi] <= fsel_wdata[gi];
						user_output_level[gi] <= pwdata[ULVL_LSB+gi];
					end
					if (fsel_change)
						output_threshold_param[gi] <= THRESH_RESET;
					else if (wr_en && hit_th[gi])
						output_threshold_param[gi] <= pwdata;
				end
			end
		end
	endgenerate

	// =====================================================
	// Auxiliary pairs
	generate
		for (gi = 0; gi < NUM_PAIRS; gi++) begin : g_pair
			aux_pair_channel u_pair (
				.pclk(pclk),
				.presetn(presetn),
				.pos_in(pair_pos_in[gi]),
				.neg_in(pair_neg_in[gi]),
				.pos_out(pair_pos_out[gi]),
				.neg_out(pair_neg_out[gi]),
				.pos_oe(pair_pos_oe[gi]),
				.neg_oe(pair_neg_oe[gi]),
				.active(aux_active),
				.dir(pair_direction[gi]),
				.inv(pair_polarity_invert[gi]),
				.user_level(aux_user_level[gi]),
				.in_level(input_level_readback[gi])
			);
		end
	endgenerate

	// =====================================================
	// Configuration writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pair_direction <= NUM_PAIRS'(PAIR_RESET);
			pair_polarity_invert <= NUM_PAIRS'(PAIR_RESET);
			emulation_mode_select <= EMU_RESET;
			aux_user_level <= NUM_PAIRS'(PAIR_RESET);
			fault_relay_policy <= RELAY_POLICY_RESET;
		end else begin
			if (wr_en && hit_ctrl) begin
				pair_direction <= pwdata[DIR_LSB +: NUM_PAIRS];
				pair_polarity_invert <= pwdata[INV_LSB +: NUM_PAIRS];
				emulation_mode_select <= pwdata[EMU_LSB +: EMU_W];
			end
			if (wr_en && hit_user)
				aux_user_level <= pwdata[NUM_PAIRS-1:0];
			if (wr_en && hit_relay)
				fault_relay_policy <= pwdata[0];
		end
	end

	// =====================================================
	// Outputs and relay
	wire next_relay = fault_relay_policy ? drive_enabled : ~drive_fault;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= '0;
			relay_closed <= 1'b0;
		end else begin
			dout <= next_dout;
			relay_closed <= next_relay;
		end
	end

	// =====================================================
	// Read data
	// The output level readback shows the user level, never the inverted pin value
	wire [31:0] rd_ctrl = 32'(pair_direction) | (32'(pair_polarity_invert) << INV_LSB)
		| (32'(emulation_mode_select) << EMU_LSB);
	wire [31:0] rd_status = 32'(input_level_readback) | (32'(aux_user_level) << OUTLVL_LSB);
	wire [31:0] rd_dctrl = 32'(output_function_select[0]) | (32'(output_function_select[1]) << FSEL_STRIDE)
		| (32'(user_output_level) << ULVL_LSB);
	wire [1:0] packed_outputs = {dout[0], dout[1]};
	wire [31:0] rd_dstat = 32'(packed_outputs) | (32'(relay_closed) << RELAY_BIT);
	wire [31:0] rd_mux =
		hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_user ? 32'(aux_user_level) :
		hit_relay ? 32'(fault_relay_policy) :
		hit_dctrl ? rd_dctrl :
		hit_th0 ? output_threshold_param[0] :
		hit_th1 ? output_threshold_param[1] :
		hit_dstat ? rd_dstat : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (setup && !pwrite)
			prdata <= rd_mux;
	end
endmodule // drive_digital_io_config
`default_nettype wire

/* File: testbench/dio_config_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module dio_config_sva import dio_pkg::*; #(
	parameter int NUM_PAIRS = 3,
	parameter int NUM_OUTS = 2
) (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [NUM_PAIRS-1:0] pair_pos_out, // Plus drive
	input wire logic [NUM_PAIRS-1:0] pair_neg_out, // Minus drive
	input wire logic [NUM_PAIRS-1:0] pair_pos_oe, // Plus enable
	input wire logic drive_fault, // Fault
	input wire logic drive_enabled, // Enabled
	input wire logic [NUM_OUTS-1:0] dout, // Outputs
	input wire logic relay_closed // Relay
);
	// ====
	// Shadow copies of the control registers, taken from bus writes
	logic [31:0] ctl;
	logic [31:0] dctl;
	logic pol;
	wire wr = psel && penable && pwrite;
	wire mapped = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
	wire act = ctl[20:16] == EMU_AUX_IO;
	wire relay_want = pol ? drive_enabled : !drive_fault;
	wire user0 = dctl[4:0] == FN_USER;
	wire fault0 = dctl[4:0] == FN_FAULT;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= '0;
			dctl <= '0;
			pol <= 1'b0;
		end else if (wr) begin
			if (paddr == AUX_CTRL_ADDR) ctl <= pwdata;
			if (paddr == DOUT_CTRL_ADDR) dctl <= pwdata;
			if (paddr == RELAY_ADDR) pol <= pwdata[0];
		end
	end
	// ====
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_zero_wait: assert property (psel && penable |-> pready) else $error("no ready in access phase");
	a_err_unmapped: assert property (psel && penable |-> pslverr == !mapped) else $error("bad slave error");
	a_oe_direction: assert property (pair_pos_oe == (act ? ctl[NUM_PAIRS-1:0] : '0)) else $error("bad enable");
	a_legs_opposite: assert property (pair_neg_out == ~pair_pos_out) else $error("legs not complementary");
	a_relay_policy: assert property ($past(presetn) |-> relay_closed == $past(relay_want))
		else $error("relay wrong");
	a_user_level: assert property ($past(presetn) && $past(user0) |-> dout[0] == $past(dctl[16]))
		else $error("user level wrong");
	a_fault_code: assert property ($past(presetn) && $past(fault0) |-> dout[0] == $past(drive_fault))
		else $error("fault code wrong");
	a_status_order: assert property (psel && penable && !pwrite && paddr == DOUT_STATUS_ADDR
		|-> prdata[4:0] == {$past(relay_closed), 2'h0, $past(dout[0]), $past(dout[1])})
		else $error("status bit order wrong");
endmodule // dio_config_sva
`default_nettype wire

/* File: testbench/field_wiring.sv */
`timescale 1ns/1ns
`default_nettype none
module field_wiring #(
	parameter int N = 3
) (
	input wire logic [N-1:0] pos_out, // Device plus legs
	input wire logic [N-1:0] neg_out, // Device minus legs
	input wire logic [N-1:0] pos_oe, // Plus enables
	input wire logic [N-1:0] neg_oe, // Minus enables
	input wire logic [N-1:0] ext_pos, // Field plus drive
	input wire logic [N-1:0] ext_neg, // Field minus drive
	output logic [N-1:0] pos_in, // Plus wire level
	output logic [N-1:0] neg_in // Minus wire level
);
	// Field drivers yield wherever the device drives, so contention is not modelled
	assign pos_in = (pos_oe & pos_out) | (~pos_oe & ext_pos);
	assign neg_in = (neg_oe & neg_out) | (~neg_oe & ext_neg);
endmodule // field_wiring
`default_nettype wire

/* File: testbench/drive_digital_io_config_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
	$display("Error %s exp %0h got %0h", n, e, s); end end
module drive_digital_io_config_bench import dio_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, relay_closed, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, wv, rv, m_ctl, m_usr, m_pol, m_dct;
	logic [31:0] m_thr [2];
	logic [2:0] pi, ni, po, no, poe, noe, ext_p, ext_n, lvl, oe_e, po_e;
	logic [20:0] st;
	logic signed [31:0] pos_v, vel_v;
	logic [1:0] dout, d;
	logic rly;
	int errors, samples_checked;
	drive_digital_io_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pair_pos_in(pi), .pair_neg_in(ni), .pair_pos_out(po), .pair_neg_out(no), .pair_pos_oe(poe),
		.pair_neg_oe(noe), .drive_fault(st[0]), .drive_enabled(st[1]), .mains_ready(st[2]), .sw_limit(st[3]),
		.move_done(st[4]), .in_position(st[5]), .drive_warning(st[6]), .motor_brake(st[7]), .homing_done(st[8]),
		.cmd_buffer_active(st[9]), .encoder_index(st[10]), .ctrl_stop_active(st[11]), .fault_power_off(st[12]),
		.position_switch_flags(st[20:13]), .position(pos_v), .velocity(vel_v), .dout(dout),
		.relay_closed(relay_closed));
	field_wiring #(.N(3)) wiring (.pos_out(po), .neg_out(no), .pos_oe(poe), .neg_oe(noe), .ext_pos(ext_p),
		.ext_neg(ext_n), .pos_in(pi), .neg_in(ni));
	// ====
	// Bus master and reference model
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic dexp(input logic [4:0] s, input logic u, input logic [31:0] t);
		logic [31:0] sp;
		logic [31:0] src;
		sp = vel_v[31] ? -vel_v : vel_v;
		src = {10'h000, st[12], ~st[11], st[10], 2'h0, st[9], |st[20:13], st[8], sp < t, sp > t, st[0], st[7],
			1'b0, st[1], st[6], pos_v < $signed(t), pos_v > $signed(t), st[5], st[4], st[3], st[2], u};
		return src[s];
	endfunction
	task automatic predict();
		logic i;
		logic p;
		logic n;
		for (int k = 0; k < 3; k++) begin
			i = m_ctl[20:16] == EMU_AUX_IO && m_ctl[8+k];
			oe_e[k] = m_ctl[20:16] == EMU_AUX_IO && m_ctl[k];
			po_e[k] = m_usr[k] ^ i;
			p = oe_e[k] ? po_e[k] : ext_p[k];
			n = oe_e[k] ? ~po_e[k] : ext_n[k];
			lvl[k] = i ? n & ~p : p & ~n;
		end
		d[0] = dexp(m_dct[4:0], m_dct[16], m_thr[0]);
		d[1] = dexp(m_dct[12:8], m_dct[17], m_thr[1]);
		rly = m_pol[0] ? st[1] : ~st[0];
	endtask
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case (a)
			AUX_CTRL_ADDR: return m_ctl;
			AUX_STATUS_ADDR: return {21'h000000, m_usr[2:0], 5'h00, lvl};
			AUX_USER_ADDR: return m_usr;
			RELAY_ADDR: return m_pol;
			DOUT_CTRL_ADDR: return m_dct;
			DOUT_THRESH0_ADDR: return m_thr[0];
			DOUT_THRESH1_ADDR: return m_thr[1];
			DOUT_STATUS_ADDR: return {27'h0000000, rly, 2'h0, d[0], d[1]};
			default: return 32'h00000000;
		endcase
	endfunction
	task automatic sweep();
		for (int a = 0; a <= 32; a += 4) begin
			apb(1'b0, a[7:0], 32'h00000000);
			`CHK("prdata", exp_rd(a[7:0]), rd)
			`CHK("pslverr", a > 28, er)
		end
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		m_ctl = 0;
		m_usr = 0;
		m_pol = 0;
		m_dct = 0;
		m_thr[0] = 0;
		m_thr[1] = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ====
	// Clock, watchdog and tests
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		repeat (30000) @(posedge pclk);
		errors++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, st, pos_v, vel_v, ext_p, ext_n} = '0;
		errors = 0;
		samples_checked = 0;
		rv = $urandom(93730);
		do_reset();
		predict();
		sweep();
		for (int i = 0; i < 64; i++) begin
			wv = $urandom;
			if (i[0]) wv[20:16] = EMU_AUX_IO;
			apb(1'b1, AUX_CTRL_ADDR, wv);
			m_ctl = wv & 32'h001F0707;
			wv = $urandom;
			apb(1'b1, AUX_USER_ADDR, wv);
			m_usr = wv & 32'h00000007;
			wv = $urandom;
			apb(1'b1, RELAY_ADDR, wv);
			m_pol = wv & 32'h00000001;
			for (int k = 0; k < 2; k++) begin
				m_thr[k] = $urandom;
				apb(1'b1, k ? DOUT_THRESH1_ADDR : DOUT_THRESH0_ADDR, m_thr[k]);
			end
			wv = $urandom & 32'h00030000;
			wv[4:0] = i[4:0];
			wv[12:8] = i[5:1];
			apb(1'b1, DOUT_CTRL_ADDR, wv);
			if (wv[4:0] != m_dct[4:0]) m_thr[0] = 0;
			if (wv[12:8] != m_dct[12:8]) m_thr[1] = 0;
			m_dct = wv;
			// Writes to a read-only place and past the map must leave every register alone
			apb(1'b1, i[1] ? DOUT_STATUS_ADDR : 8'h24, 32'hFFFFFFFF);
			rv = $urandom;
			{ext_p, ext_n, st} <= rv[26:0];
			pos_v <= $urandom;
			vel_v <= $urandom;
			repeat (4) @(posedge pclk);
			predict();
			`CHK("dout", d, dout)
			`CHK("relay_closed", rly, relay_closed)
			`CHK("pair_pos_oe", oe_e, poe)
			`CHK("pair_pos_out", po_e & oe_e, po & poe)
			`CHK("pair_neg_oe", oe_e, noe)
			`CHK("pair_neg_out", ~po_e & oe_e, no & noe)
			sweep();
		end
		do_reset();
		predict();
		sweep();
		stop_test();
	end
endmodule // drive_digital_io_config_bench
bind drive_digital_io_config dio_config_sva #(.NUM_PAIRS(NUM_PAIRS), .NUM_OUTS(NUM_OUTS)) sva (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pair_pos_out(pair_pos_out), .pair_neg_out(pair_neg_out),
	.pair_pos_oe(pair_pos_oe), .drive_fault(drive_fault), .drive_enabled(drive_enabled), .dout(dout),
	.relay_closed(relay_closed));
`default_nettype wire
